// *** timer_two_pkg.sv ***
// Package for the second 8-bit PWM timer: register map, field layout,
// reset values and the clock-source, routing and prescale encodings.
// Assumes a CPU-side I/O port with byte-wide read and write strobes.
package timer_two_pkg;

   // I/O addresses of the timer registers.
   localparam logic [7:0] ADDR_CONTROL = 8'h30;
   localparam logic [7:0] ADDR_COUNT   = 8'h31;
   localparam logic [7:0] ADDR_DIVIDER = 8'h32;
   localparam logic [7:0] ADDR_LIMIT   = 8'h33;

   // Reset values.
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [7:0] RESET_COUNT   = 8'h00;
   localparam logic [7:0] RESET_DIVIDER = 8'h00;
   localparam logic [7:0] RESET_LIMIT   = 8'h00;

   // Field positions of the control register.
   localparam int CTRL_SRC_LSB   = 4;
   localparam int CTRL_ROUTE_LSB = 2;
   localparam int CTRL_MODE_BIT  = 1;
   localparam int CTRL_INV_BIT   = 0;

   // Field positions of the divider register.
   localparam int DIV_RES_BIT   = 7;
   localparam int DIV_PRE_LSB   = 5;
   localparam int DIV_SCALE_LSB = 0;

   // Clock-source codes.
   localparam logic [3:0] SRC_NONE     = 4'h0;
   localparam logic [3:0] SRC_SYSTEM   = 4'h1;
   localparam logic [3:0] SRC_FAST_OSC = 4'h2;
   localparam logic [3:0] SRC_EXT_OSC  = 4'h3;
   localparam logic [3:0] SRC_SLOW_OSC = 4'h4;
   localparam logic [3:0] SRC_COMPARE  = 4'h5;
   localparam logic [3:0] SRC_A0_RISE  = 4'h8;
   localparam logic [3:0] SRC_A0_FALL  = 4'h9;
   localparam logic [3:0] SRC_B0_RISE  = 4'hA;
   localparam logic [3:0] SRC_B0_FALL  = 4'hB;
   localparam logic [3:0] SRC_A4_RISE  = 4'hC;
   localparam logic [3:0] SRC_A4_FALL  = 4'hD;

   // Output routing codes.
   localparam logic [1:0] ROUTE_OFF = 2'h0;
   localparam logic [1:0] ROUTE_B2  = 2'h1;
   localparam logic [1:0] ROUTE_A3  = 2'h2;
   localparam logic [1:0] ROUTE_B4  = 2'h3;

   // Prescaler terminal masks: code n divides by 4 to the n.
   localparam logic [5:0] PRE_MASK_1  = 6'h00;
   localparam logic [5:0] PRE_MASK_4  = 6'h03;
   localparam logic [5:0] PRE_MASK_16 = 6'h0F;
   localparam logic [5:0] PRE_MASK_64 = 6'h3F;

   // Control register contents.
   typedef struct packed {
      logic [3:0] source;
      logic [1:0] route;
      logic       pwm_mode;
      logic       invert;
   } control_t;

   // Divider register contents.
   typedef struct packed {
      logic       reduced;
      logic [1:0] prescale;
      logic [4:0] scale;
   } divider_t;

   // External timing sources as levels, synchronised into the clk domain before use.
   typedef struct packed {
      logic fast_osc;
      logic ext_osc;
      logic slow_osc;
      logic compare;
      logic pin_a0;
      logic pin_b0;
      logic pin_a4;
   } sources_t;

   // Terminal mask for a prescaler code.
   function automatic logic [5:0] prescale_mask(input logic [1:0] code);
      unique case (code)
         2'h0: prescale_mask = PRE_MASK_1;
         2'h1: prescale_mask = PRE_MASK_4;
         2'h2: prescale_mask = PRE_MASK_16;
         2'h3: prescale_mask = PRE_MASK_64;
      endcase
   endfunction

endpackage

// *** timer_two_sync.sv ***
// Two-flop synchroniser for a bundle of levels from outside clk.
// Assumes each bit changes slower than clk; holds state while ce is low.
module timer_two_sync #(
   parameter int WIDTH = 7
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] first;

   // Only the second stage reads the first stage.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         first    <= '0;
         sync_out <= '0;
      end else if (ce) begin
         first    <= async_in;
         sync_out <= first;
      end
   end

endmodule

// *** timer_two_divider.sv ***
// Prescaler and 5-bit scaler that thin a tick stream.
// Assumes tick_in is a one-cycle pulse from the clock-source selector.
module timer_two_divider (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic [1:0] prescale,
   input  wire logic [4:0] scale,
   input  wire logic       tick_in,
   output logic            tick_out
);

   logic [5:0] pre_count;
   logic [4:0] scale_count;
   logic       pre_tick;

   // Prescaler passes every 1st, 4th, 16th or 64th tick.
   assign pre_tick = tick_in &&
      ((pre_count & timer_two_pkg::prescale_mask(prescale)) ==
       timer_two_pkg::prescale_mask(prescale)); // see R9

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_count <= 6'h00;
      end else if (ce && tick_in) begin
         pre_count <= pre_tick ? 6'h00 : pre_count + 6'h01; // see R9
      end
   end

   // Scaler passes one prescaled tick in scale+1.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scale_count <= 5'h00;
         tick_out    <= 1'b0;
      end else if (ce) begin
         tick_out <= 1'b0;
         if (pre_tick) begin
            if (scale_count >= scale) begin
               scale_count <= 5'h00;
               tick_out    <= 1'b1; // see R14
            end else begin
               scale_count <= scale_count + 5'h01; // see R10
            end
         end
      end
   end

endmodule

// *** timer_two_pwm_counter.sv ***
// Second 8-bit timer with selectable clock, prescaler, scaler,
// period or PWM mode and routable, invertible output.
// Assumes a byte-wide I/O port with one-cycle read and write strobes.
//
// Overview of operation
// R1: Source codes 0-4 pick no clock, system clock, fast, external or slow oscillator.
// R2: Source code 5 counts on the comparator result output.
// R3: Codes 8 to D count rising or falling edges of pins A0, B0 and A4; others halt.
// R4: The routing field sends the output nowhere, to B2, A3 or B4.
// R5: The mode bit selects period mode when clear and PWM mode when set.
// R6: Control bit 0 inverts the output before it reaches the pin.
// R7: The 8-bit counter is readable and writable and resets to zero.
// R8: Divider bit 7 selects 8-bit PWM or the build-time reduced width.
// R9: The prescaler divides the selected clock by 1, 4, 16 or 64.
// R10: The 5-bit scaler field adds a further division and resets to zero.
// R11: All control fields reset to zero, leaving the timer idle.
// R12: A write-only 8-bit limit register at 0x33 resets to zero.
// R13: The counter steps per divided tick; in period mode the output toggles on match or wrap.
// R14: The scaler divides by its value plus one.
module timer_two_pwm_counter #(
   parameter bit fast_clock_doubling_option = 1'b0,
   parameter bit reduced_pwm_width_option   = 1'b0
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic [7:0] io_addr,
   input  wire logic [7:0] io_wdata,
   input  wire logic       io_write,
   input  wire logic       io_read,
   output logic      [7:0] io_rdata,
   input  wire logic       fast_internal_oscillator,
   input  wire logic       fast_internal_oscillator_double,
   input  wire logic       external_oscillator,
   input  wire logic       slow_internal_oscillator,
   input  wire logic       comparator_result,
   input  wire logic       port_a_pin_zero,
   input  wire logic       port_b_pin_zero,
   input  wire logic       port_a_pin_four,
   output logic            port_b_pin_two,
   output logic            port_b_pin_two_oe,
   output logic            port_a_pin_three,
   output logic            port_a_pin_three_oe,
   output logic            port_b_pin_four,
   output logic            port_b_pin_four_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Registers and synchronised sources.

   timer_two_pkg::control_t control;
   timer_two_pkg::divider_t divider;
   timer_two_pkg::sources_t raw_src;
   timer_two_pkg::sources_t sync_src;
   timer_two_pkg::sources_t last_src;
   logic [7:0]              count;
   logic [7:0]              limit;
   logic                    wave;
   logic                    src_tick;
   logic                    tick;
   logic [7:0]              top;
   logic                    out_level;

   // Chosen fast oscillator: plain or doubled rate.
   assign raw_src = '{
      fast_osc: fast_clock_doubling_option ? fast_internal_oscillator_double
                                           : fast_internal_oscillator,
      ext_osc:  external_oscillator,
      slow_osc: slow_internal_oscillator,
      compare:  comparator_result,
      pin_a0:   port_a_pin_zero,
      pin_b0:   port_b_pin_zero,
      pin_a4:   port_a_pin_four
   };

   timer_two_sync #(
      .WIDTH ($bits(timer_two_pkg::sources_t))
   ) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .ce       (ce),
      .async_in (raw_src),
      .sync_out (sync_src)
   );

   // Previous synchronised levels for edge detection.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_src <= '0;
      end else if (ce) begin
         last_src <= sync_src;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock-source selection: one tick per source edge.

   always_comb begin
      unique case (control.source)
         timer_two_pkg::SRC_SYSTEM:   src_tick = 1'b1; // see R1
         timer_two_pkg::SRC_FAST_OSC: src_tick = sync_src.fast_osc && !last_src.fast_osc;
         timer_two_pkg::SRC_EXT_OSC:  src_tick = sync_src.ext_osc && !last_src.ext_osc;
         timer_two_pkg::SRC_SLOW_OSC: src_tick = sync_src.slow_osc && !last_src.slow_osc;
         timer_two_pkg::SRC_COMPARE:  src_tick = sync_src.compare && !last_src.compare; // see R2
         timer_two_pkg::SRC_A0_RISE:  src_tick = sync_src.pin_a0 && !last_src.pin_a0; // see R3
         timer_two_pkg::SRC_A0_FALL:  src_tick = !sync_src.pin_a0 && last_src.pin_a0;
         timer_two_pkg::SRC_B0_RISE:  src_tick = sync_src.pin_b0 && !last_src.pin_b0;
         timer_two_pkg::SRC_B0_FALL:  src_tick = !sync_src.pin_b0 && last_src.pin_b0;
         timer_two_pkg::SRC_A4_RISE:  src_tick = sync_src.pin_a4 && !last_src.pin_a4;
         timer_two_pkg::SRC_A4_FALL:  src_tick = !sync_src.pin_a4 && last_src.pin_a4;
         default:                     src_tick = 1'b0; // see R1, R3
      endcase
   end

   timer_two_divider u_divider (
      .clk      (clk),
      .resetn   (resetn),
      .ce       (ce),
      .prescale (divider.prescale),
      .scale    (divider.scale),
      .tick_in  (src_tick),
      .tick_out (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register writes.

   // Control, divider and limit registers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         control <= timer_two_pkg::RESET_CONTROL; // see R11
         divider <= timer_two_pkg::RESET_DIVIDER; // see R10
         limit   <= timer_two_pkg::RESET_LIMIT; // see R12
      end else if (ce && io_write) begin
         unique case (io_addr)
            timer_two_pkg::ADDR_CONTROL: control <= io_wdata;
            timer_two_pkg::ADDR_DIVIDER: divider <= io_wdata; // see R8
            timer_two_pkg::ADDR_LIMIT:   limit   <= io_wdata; // see R12
            default: ;
         endcase
      end
   end

   // Wrap value for the selected width.
   always_comb begin
      if (control.pwm_mode && divider.reduced) begin
         top = reduced_pwm_width_option ? 8'h7F : 8'h3F; // see R8
      end else begin
         top = 8'hFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter and output wave.

   // A software write to the counter takes priority over a tick.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= timer_two_pkg::RESET_COUNT; // see R7
      end else if (ce) begin
         if (io_write && io_addr == timer_two_pkg::ADDR_COUNT) begin
            count <= io_wdata; // see R7
         end else if (tick) begin
            count <= (count >= top) ? 8'h00 : count + 8'h01; // see R13
         end
      end
   end

   // PWM: high from wrap, low at limit match; period: toggle on limit and on wrap.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wave <= 1'b0;
      end else if (ce && tick) begin
         if (control.pwm_mode) begin
            if (count >= top) begin
               wave <= 1'b1; // see R5
            end else if (count == limit) begin
               wave <= 1'b0; // see R13
            end
         end else if (count == limit || count >= top) begin
            wave <= ~wave; // see R5, R13
         end
      end
   end

   assign out_level = wave ^ control.invert; // see R6

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers and read data, all registered.

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         port_b_pin_two      <= 1'b0;
         port_b_pin_two_oe   <= 1'b0;
         port_a_pin_three    <= 1'b0;
         port_a_pin_three_oe <= 1'b0;
         port_b_pin_four     <= 1'b0;
         port_b_pin_four_oe  <= 1'b0;
      end else if (ce) begin
         port_b_pin_two      <= out_level;
         port_a_pin_three    <= out_level;
         port_b_pin_four     <= out_level;
         port_b_pin_two_oe   <= control.route == timer_two_pkg::ROUTE_B2; // see R4
         port_a_pin_three_oe <= control.route == timer_two_pkg::ROUTE_A3; // see R4
         port_b_pin_four_oe  <= control.route == timer_two_pkg::ROUTE_B4; // see R4
      end
   end

   // Only control and counter read back; write-only registers read zero.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_rdata <= 8'h00;
      end else if (ce && io_read) begin
         unique case (io_addr)
            timer_two_pkg::ADDR_CONTROL: io_rdata <= control;
            timer_two_pkg::ADDR_COUNT:   io_rdata <= count; // see R7
            default:                     io_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   a_count_write: assert property (@(posedge clk) disable iff (!resetn) // see R7
      ce && io_write && io_addr == timer_two_pkg::ADDR_COUNT |=> count == $past(io_wdata))
      else $error("counter write not taken");

   a_halt_no_count: assert property (@(posedge clk) disable iff (!resetn) // see R1
      control.source == timer_two_pkg::SRC_NONE && $past(control.source) == timer_two_pkg::SRC_NONE
      && !(io_write && io_addr == timer_two_pkg::ADDR_COUNT) |=> $stable(count))
      else $error("counter moved with no clock");

   a_route_off: assert property (@(posedge clk) disable iff (!resetn) // see R4
      ce && control.route == timer_two_pkg::ROUTE_OFF |=>
      !port_b_pin_two_oe && !port_a_pin_three_oe && !port_b_pin_four_oe)
      else $error("pin driven with routing off");

   a_route_b2: assert property (@(posedge clk) disable iff (!resetn) // see R4
      ce && control.route == timer_two_pkg::ROUTE_B2 |=> port_b_pin_two_oe && !port_b_pin_four_oe)
      else $error("routing to B2 wrong");

   a_route_a3: assert property (@(posedge clk) disable iff (!resetn) // see R4
      ce && control.route == timer_two_pkg::ROUTE_A3 |=>
      port_a_pin_three_oe && !port_b_pin_two_oe && !port_b_pin_four_oe)
      else $error("routing to A3 wrong");

   a_route_b4: assert property (@(posedge clk) disable iff (!resetn) // see R4
      ce && control.route == timer_two_pkg::ROUTE_B4 |=>
      port_b_pin_four_oe && !port_a_pin_three_oe && !port_b_pin_two_oe)
      else $error("routing to B4 wrong");

   a_invert_out: assert property (@(posedge clk) disable iff (!resetn) // see R6
      ce |=> port_b_pin_two == ($past(wave) ^ $past(control.invert)))
      else $error("output polarity wrong");

   a_pwm_high_wrap: assert property (@(posedge clk) disable iff (!resetn) // see R5
      ce && tick && control.pwm_mode && count >= top |=> wave)
      else $error("pwm not high after wrap");

   a_pwm_low_match: assert property (@(posedge clk) disable iff (!resetn) // see R13
      ce && tick && control.pwm_mode && count < top && count == limit |=> !wave)
      else $error("pwm not low after limit match");

   a_period_toggle: assert property (@(posedge clk) disable iff (!resetn) // see R5, R13
      ce && tick && !control.pwm_mode && (count == limit || count == 8'hFF)
      |=> wave != $past(wave))
      else $error("period output did not toggle");

   a_count_step: assert property (@(posedge clk) disable iff (!resetn) // see R13
      ce && tick && !io_write && count < top |=> count == $past(count) + 8'h01)
      else $error("counter did not step");

   a_reduced_top: assert property (@(posedge clk) disable iff (!resetn) // see R8
      ce && tick && control.pwm_mode && divider.reduced && !io_write
      |=> count <= (reduced_pwm_width_option ? 8'h7F : 8'h3F))
      else $error("reduced width exceeded");

   a_system_tick: assert property (@(posedge clk) disable iff (!resetn) // see R9, R14
      ce && control.source == timer_two_pkg::SRC_SYSTEM && divider == 8'h00 |=> tick)
      else $error("system clock not ticking");

   a_limit_write: assert property (@(posedge clk) disable iff (!resetn) // see R12
      ce && io_write && io_addr == timer_two_pkg::ADDR_LIMIT |=> limit == $past(io_wdata))
      else $error("limit write not taken");

   a_count_read: assert property (@(posedge clk) disable iff (!resetn) // see R7
      ce && io_read && io_addr == timer_two_pkg::ADDR_COUNT |=> io_rdata == $past(count))
      else $error("counter read wrong");

   a_divider_write: assert property (@(posedge clk) disable iff (!resetn) // see R8, R10
      ce && io_write && io_addr == timer_two_pkg::ADDR_DIVIDER |=> divider == $past(io_wdata))
      else $error("divider write not taken");

   c_pwm_run: cover property (@(posedge clk) disable iff (!resetn) control.pwm_mode && tick);
   c_period_toggle: cover property (@(posedge clk) disable iff (!resetn)
      !control.pwm_mode && tick && count == limit);
   c_pin_edge: cover property (@(posedge clk) disable iff (!resetn)
      control.source == timer_two_pkg::SRC_A0_FALL && src_tick);
   c_scaled: cover property (@(posedge clk) disable iff (!resetn) divider.scale != 5'h00 && tick);

endmodule

// *** testbench.sv ***
// Self-checking testbench for the second 8-bit PWM timer.
// Assumes the timer package and all design files are compiled before it.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk;
   logic       resetn;
   logic [7:0] io_addr;
   logic [7:0] io_wdata;
   logic       io_write;
   logic       io_read;
   logic [7:0] io_rdata;
   logic [7:0] src;
   logic [2:0] pin;
   logic [2:0] oe;
   int         fails;
   int         num_checks;
   int         cycles;

   ////////////////////////////////////////////////////////////////////////////////////////
   // The timer with both build options left at their defaults; src bit 1 is the doubled rate.
   timer_two_pwm_counter dut (
      .clk                             (clk),
      .resetn                          (resetn),
      .ce                              (1'b1),
      .io_addr                         (io_addr),
      .io_wdata                        (io_wdata),
      .io_write                        (io_write),
      .io_read                         (io_read),
      .io_rdata                        (io_rdata),
      .fast_internal_oscillator        (src[0]),
      .fast_internal_oscillator_double (src[1]),
      .external_oscillator             (src[2]),
      .slow_internal_oscillator        (src[3]),
      .comparator_result               (src[4]),
      .port_a_pin_zero                 (src[5]),
      .port_b_pin_zero                 (src[6]),
      .port_a_pin_four                 (src[7]),
      .port_b_pin_two                  (pin[0]),
      .port_b_pin_two_oe               (oe[0]),
      .port_a_pin_three                (pin[1]),
      .port_a_pin_three_oe             (oe[1]),
      .port_b_pin_four                 (pin[2]),
      .port_b_pin_four_oe              (oe[2])
   );

   // Free-running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Checks made %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Exact comparison.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Comparison against a window, for edges that may fall either side of a sample.
   task automatic chk_in(input int got, input int lo, input int hi);
      num_checks++;
      if (got < lo || got > hi) begin
         fails++;
         $display("BAD at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
      end
   endtask

   // One write cycle; the strobe drops at the taking edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      io_addr  <= a;
      io_wdata <= d;
      io_write <= 1'b1;
      @(posedge clk);
      io_write <= 1'b0;
   endtask

   // One read cycle; the registered data is taken once the taking edge has settled.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      io_addr <= a;
      io_read <= 1'b1;
      @(posedge clk);
      io_read <= 1'b0;
      #1;
      d = io_rdata;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // Reset contents and idle pins.
   task automatic reset_check();
      logic [7:0] d;
      chk(16'({pin, oe}), 16'h0000);
      rd(timer_two_pkg::ADDR_CONTROL, d);
      chk(16'(d), 16'(timer_two_pkg::RESET_CONTROL));
      rd(timer_two_pkg::ADDR_COUNT, d);
      chk(16'(d), 16'(timer_two_pkg::RESET_COUNT));
   endtask

   // Every routing code with inversion on, while the wave rests low.
   task automatic routes();
      for (int r = 0; r < 4; r++) begin
         wr(timer_two_pkg::ADDR_CONTROL, {timer_two_pkg::SRC_NONE, 2'(r), 2'b01});
         repeat (2) @(posedge clk);
         #1;
         chk(16'(oe), 16'(r == 0 ? 0 : 1 << (r - 1)));
         chk(16'(pin), 16'h0007);
      end
   endtask

   // Access kinds, write-only places, and an unmapped address.
   task automatic regs();
      logic [7:0] d;
      wr(timer_two_pkg::ADDR_CONTROL, 8'hA7);
      wr(8'h34, 8'hFF);
      rd(timer_two_pkg::ADDR_CONTROL, d);
      chk(16'(d), 16'h00A7);
      wr(timer_two_pkg::ADDR_COUNT, 8'h5A);
      rd(timer_two_pkg::ADDR_COUNT, d);
      chk(16'(d), 16'h005A);
      wr(timer_two_pkg::ADDR_DIVIDER, 8'hFF);
      rd(timer_two_pkg::ADDR_DIVIDER, d);
      chk(16'(d), 16'h0000);
      wr(timer_two_pkg::ADDR_LIMIT, 8'h77);
      rd(timer_two_pkg::ADDR_LIMIT, d);
      chk(16'(d), 16'h0000);
      rd(8'h34, d);
      chk(16'(d), 16'h0000);
      wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
   endtask

   // Counter advance across two reads taken exactly n cycles apart.
   task automatic rate(input logic [7:0] div, input int n, input logic [7:0] exp);
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] diff;
      wr(timer_two_pkg::ADDR_DIVIDER, div);
      rd(timer_two_pkg::ADDR_COUNT, a);
      repeat (n - 2) @(posedge clk);
      rd(timer_two_pkg::ADDR_COUNT, b);
      diff = b - a;
      chk(16'(diff), 16'(exp));
   endtask

   // Input that a source code listens to; reserved and halted codes get every input.
   function automatic logic [7:0] src_mask(input logic [3:0] code);
      case (code)
         4'h2: src_mask = 8'h01;
         4'h3: src_mask = 8'h04;
         4'h4: src_mask = 8'h08;
         4'h5: src_mask = 8'h10;
         4'h8, 4'h9: src_mask = 8'h20;
         4'hA, 4'hB: src_mask = 8'h40;
         4'hC, 4'hD: src_mask = 8'h80;
         default: src_mask = 8'hFF;
      endcase
   endfunction

   // One pulse on the selected input; counts after its rise and after its fall.
   task automatic edge_count(input logic [3:0] code);
      logic [7:0] m;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] up;
      logic [7:0] down;
      m = src_mask(code);
      up = (m == 8'hFF || (code[3] && code[0])) ? 8'h00 : 8'h01;
      down = (m == 8'hFF) ? 8'h00 : 8'h01;
      wr(timer_two_pkg::ADDR_CONTROL, {code, 4'h0});
      repeat (6) @(posedge clk);
      rd(timer_two_pkg::ADDR_COUNT, a);
      @(posedge clk);
      src <= m;
      repeat (8) @(posedge clk);
      rd(timer_two_pkg::ADDR_COUNT, b);
      @(posedge clk);
      src <= 8'h00;
      repeat (8) @(posedge clk);
      rd(timer_two_pkg::ADDR_COUNT, c);
      b = b - a;
      c = c - a;
      chk(16'(b), 16'(up));
      chk(16'(c), 16'(down));
   endtask

   // High cycles and level changes of the port B pin two output over n cycles, then judged.
   task automatic duty(input logic [7:0] ctrl, input logic [7:0] div, input logic [7:0] lim,
                       input int n, input int lo, input int hi, input int fl);
      logic prev;
      int   high;
      int   flips;
      wr(timer_two_pkg::ADDR_LIMIT, lim);
      wr(timer_two_pkg::ADDR_DIVIDER, div);
      wr(timer_two_pkg::ADDR_CONTROL, ctrl);
      repeat (300) @(posedge clk);
      #1;
      high = 0;
      flips = 0;
      prev = pin[0];
      repeat (n) begin
         @(posedge clk);
         #1;
         high += int'(pin[0] === 1'b1);
         flips += int'(pin[0] !== prev);
         prev = pin[0];
      end
      chk_in(high, lo, hi);
      chk(16'(flips), 16'(fl));
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // Hang guard: the whole sequence needs well under this many cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails++;
         stop_test();
      end
   end

   // Main sequence.
   initial begin
      resetn = 1'b0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
      io_write = 1'b0;
      io_read = 1'b0;
      src = 8'h00;
      fails = 0;
      num_checks = 0;
      cycles = 0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      reset_check();
      routes();
      regs();
      wr(timer_two_pkg::ADDR_CONTROL, 8'h10);
      rate(8'h00, 40, 8'd40);
      rate(8'h20, 64, 8'd16);
      rate(8'h40, 64, 8'd4);
      rate(8'h60, 128, 8'd2);
      rate(8'h04, 100, 8'd20);
      rate(8'h22, 120, 8'd10);
      wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
      rate(8'h00, 40, 8'd0);
      for (int k = 0; k < 16; k++) begin
         if (k != 1) begin
            edge_count(4'(k));
         end
      end
      duty(8'h16, 8'h00, 8'h40, 256, 8'h40, 8'h41, 2);
      duty(8'h17, 8'h00, 8'h40, 256, 8'hBF, 8'hC0, 2);
      duty(8'h16, 8'h00, 8'h10, 256, 8'h10, 8'h11, 2);
      duty(8'h16, 8'h80, 8'h10, 256, 8'h40, 8'h44, 8);
      duty(8'h14, 8'h00, 8'h40, 1024, 260, 764, 8);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      reset_check();
      stop_test();
   end
endmodule
